//--- hw/pif_top.sv
// Purpose: Peripheral interrupt flag registers six to nine with an interrupt summary.
// Assumes: Event inputs are one-cycle pulses on hclk; summary sources are levels on hclk.
// Notes: Only external pins are synchronised; they reach logic two edges late.
// Overview of operation
// - Flags set on their event regardless of any interrupt enable.
// - Hardware-set flags read 1 after the event until software writes 0.
// - All flag bits reset to 0 on every reset.
// - UART2 summary flag bit 5 is read-only, clears when UART status clears.
// - UART2 error summary bit 4 is read-only, clears when error status clears.
// - UART2 transmit bit 3 and receive bit 2 follow the UART only.
// - Two-wire error summary bit 1 is read-only, clear when error register clears.
// - Two-wire summary bit 0 is read-only, clear when its status register clears.
// - Register six holds timer 3 gate flag bit 7 and overflow bit 6.
// - Register seven maps ext irq 2, cell 2, wave 2, capcomp 2, timer 4.
// - External interrupt 2 pin is chosen by a pin-select register.
// - Register eight holds timer 5 gate bit 7 and overflow bit 6 only.
// - Register nine maps cell 3, wave 3, capcomp 3, timer 6 in bits 3-0.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "pif_map.svh"
module pif_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pif_pkg::pif_events_s ev,
  input wire pif_pkg::pif_sources_s src,
  input wire logic [`PIF_PIN_COUNT-1:0] ext_pins,
  output logic [31:0] flags_out,
  output logic irq
);
  import pif_pkg::*;

  localparam logic [3:0][7:0] WMASK = {`PIF_WMASK_NINE, `PIF_WMASK_EIGHT,
                                       `PIF_WMASK_SEVEN, `PIF_WMASK_SIX};

  pif_state_s st_reg;
  pif_state_s st_next;
  pif_reg_req_s req;
  logic [31:0] rd_value;
  logic [`PIF_PIN_COUNT-1:0] pins_sync;
  logic [3:0][7:0] hw_set;
  logic [3:0] wr_hit;
  logic wr_pinsel;
  logic wr_clear;
  logic wr_enable;
  logic ext_level;
  logic ext_edge;
  logic [5:0] summary;
  logic [31:0] rise;

  pif_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .req(req),
    .rd_value(rd_value)
  );

  pif_sync #(
    .W(`PIF_PIN_COUNT)
  ) u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(ext_pins),
    .q(pins_sync)
  );

  // Pin selection and edge detection for external interrupt 2.
  always_comb begin
    ext_level = pins_sync[st_reg.pin_sel];
    if (st_reg.edge_falling) begin
      ext_edge = st_reg.ext_prev & ~ext_level;
    end else begin
      ext_edge = ~st_reg.ext_prev & ext_level;
    end
  end

  // Event sources placed at their bit positions; zeros mark unused bits.
  always_comb begin
    hw_set[0] = {ev.timer3_gate_flag, ev.timer3_overflow_flag, 6'h00};
    hw_set[1] = {2'b00, ext_edge, ev.logic_cell2_flag, ev.wave_gen2_flag, 1'b0,
                 ev.capcomp2_flag, ev.timer4_flag};
    hw_set[2] = {ev.timer5_gate_flag, ev.timer5_overflow_flag, 6'h00};
    hw_set[3] = {4'h0, ev.logic_cell3_flag, ev.wave_gen3_flag, ev.capcomp3_flag,
                 ev.timer6_flag};
    summary[5] = |src.uart_irq_status_reg;
    summary[4] = |src.uart_error_status_reg;
    summary[3] = src.uart2_transmit_flag;
    summary[2] = src.uart2_receive_flag;
    summary[1] = |src.twowire_error_reg;
    summary[0] = |src.twowire_irq_status_reg;
  end

  // Address decode; unmapped addresses read zero and ignore writes.
  always_comb begin
    wr_hit = 4'h0;
    wr_pinsel = 1'b0;
    wr_clear = 1'b0;
    wr_enable = 1'b0;
    rd_value = `PIF_WORD_RST;
    if (req.addr == `PIF_OFS_FLAGS_SIX) begin
      wr_hit[0] = req.wr_en;
      rd_value = {24'h000000, st_reg.flags[0]};
    end else if (req.addr == `PIF_OFS_FLAGS_SEVEN) begin
      wr_hit[1] = req.wr_en;
      rd_value = {24'h000000, st_reg.flags[1]};
    end else if (req.addr == `PIF_OFS_FLAGS_EIGHT) begin
      wr_hit[2] = req.wr_en;
      rd_value = {24'h000000, st_reg.flags[2]};
    end else if (req.addr == `PIF_OFS_FLAGS_NINE) begin
      wr_hit[3] = req.wr_en;
      rd_value = {24'h000000, st_reg.flags[3]};
    end else if (req.addr == `PIF_OFS_PIN_SELECT) begin
      wr_pinsel = req.wr_en;
      rd_value[`PIF_PINSEL_W-1:0] = st_reg.pin_sel;
      rd_value[`PIF_EDGE_BIT] = st_reg.edge_falling;
    end else if (req.addr == `PIF_OFS_IRQ_STATUS) begin
      rd_value = st_reg.irq_status;
    end else if (req.addr == `PIF_OFS_IRQ_CLEAR) begin
      wr_clear = req.wr_en;
    end else if (req.addr == `PIF_OFS_IRQ_ENABLE) begin
      wr_enable = req.wr_en;
      rd_value = st_reg.irq_enable;
    end
  end

  // Next state. A hardware set in the same cycle as a software clear wins,
  // so no event is lost when software clears a flag late.
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < 4; i++) begin
      if (wr_hit[i]) begin
        st_next.flags[i] = req.wdata[7:0] & WMASK[i];
      end
      st_next.flags[i] = (st_next.flags[i] & WMASK[i]) | (hw_set[i] & WMASK[i]);
    end
    // Read-only summaries track their sources every cycle and ignore writes.
    st_next.flags[0][5:0] = summary;
    st_next.ext_prev = ext_level;
    if (wr_pinsel) begin
      st_next.pin_sel = req.wdata[`PIF_PINSEL_W-1:0];
      st_next.edge_falling = req.wdata[`PIF_EDGE_BIT];
    end
    if (wr_enable) begin
      st_next.irq_enable = req.wdata;
    end
    rise = st_next.flags & ~st_reg.flags;
    if (wr_clear) begin
      st_next.irq_status = st_reg.irq_status & ~req.wdata;
    end
    st_next.irq_status = st_next.irq_status | rise;
    st_next.irq = |(st_next.irq_status & st_next.irq_enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.flags <= {4{`PIF_FLAGS_RST}};
      st_reg.ext_prev <= 1'b0;
      st_reg.pin_sel <= `PIF_PINSEL_RST;
      st_reg.edge_falling <= 1'b0;
      st_reg.irq_status <= `PIF_WORD_RST;
      st_reg.irq_enable <= `PIF_WORD_RST;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags_out = st_reg.flags;
  assign irq = st_reg.irq;

  chk_set_no_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer4_flag |=> st_reg.flags[1][0] && st_reg.irq_status[8])
    else $error("timer 4 event did not set its flag");

  chk_flag_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.flags[2][7] && !wr_hit[2] |=> st_reg.flags[2][7])
    else $error("hardware set flag dropped without a write");

  chk_write_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_hit[3] && !req.wdata[0] && !ev.timer6_flag |=> !st_reg.flags[3][0])
    else $error("writing zero did not clear the flag");

  chk_reset_clear: assert property (
    @(posedge hclk)
    $rose(hresetn) |-> st_reg.flags == '0 && !irq)
    else $error("flags not clear after reset");

  chk_uart_summary: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 st_reg.flags[0][5] == $past(|src.uart_irq_status_reg))
    else $error("uart summary flag does not follow uart status");

  chk_uart_error: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src.uart_error_status_reg == 8'h00 |=> !st_reg.flags[0][4])
    else $error("uart error summary set with clean error status");

  chk_uart_txrx: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_hit[0] |=> st_reg.flags[0][3:2] ==
      $past({src.uart2_transmit_flag, src.uart2_receive_flag}))
    else $error("software write moved uart transmit or receive flag");

  chk_twowire_error: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|src.twowire_error_reg) |=> st_reg.flags[0][1])
    else $error("two-wire error summary missed its source");

  chk_twowire_sum: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src.twowire_irq_status_reg == 8'h00 [*2] |-> !st_reg.flags[0][0])
    else $error("two-wire summary set with clear status");

  chk_timer3_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer3_gate_flag |=> st_reg.flags[0][7] && st_reg.irq_status[7])
    else $error("timer 3 gate event not recorded");

  chk_seven_unused: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.flags[1][7:6] == 2'b00 && !st_reg.flags[1][2])
    else $error("unused bits of register seven read nonzero");

  chk_ext_select: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !st_reg.edge_falling && !st_reg.ext_prev && pins_sync[st_reg.pin_sel]
    |=> st_reg.flags[1][5])
    else $error("selected pin edge did not set external flag");

  chk_eight_unused: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.flags[2][5:0] == 6'h00)
    else $error("unused bits of register eight read nonzero");

  chk_nine_unused: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.flags[3][7:4] == 4'h0)
    else $error("unused bits of register nine read nonzero");

  chk_ignore_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_hit[1] && req.wdata[7:6] == 2'b11 |=> st_reg.flags[1][7:6] == 2'b00
      && st_reg.irq_status[15:14] == 2'b00)
    else $error("write to unused bits had an effect");

  // Each event must land in its own bit one edge later, whatever the enables hold.
  chk_timer3_ovf: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer3_overflow_flag |=> st_reg.flags[0][6])
    else $error("timer 3 overflow event not recorded");

  chk_cell2_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.logic_cell2_flag |=> st_reg.flags[1][4])
    else $error("logic cell 2 event not recorded");

  chk_wave2_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.wave_gen2_flag |=> st_reg.flags[1][3])
    else $error("waveform generator 2 event not recorded");

  chk_capcomp2_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.capcomp2_flag |=> st_reg.flags[1][1])
    else $error("capture compare 2 event not recorded");

  chk_timer5_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer5_gate_flag |=> st_reg.flags[2][7])
    else $error("timer 5 gate event not recorded");

  chk_timer5_ovf: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer5_overflow_flag |=> st_reg.flags[2][6])
    else $error("timer 5 overflow event not recorded");

  chk_cell3_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.logic_cell3_flag |=> st_reg.flags[3][3])
    else $error("logic cell 3 event not recorded");

  chk_wave3_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.wave_gen3_flag |=> st_reg.flags[3][2])
    else $error("waveform generator 3 event not recorded");

  chk_capcomp3_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.capcomp3_flag |=> st_reg.flags[3][1])
    else $error("capture compare 3 event not recorded");

  chk_timer6_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer6_flag |=> st_reg.flags[3][0])
    else $error("timer 6 event not recorded");

  chk_ext_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.flags[1][5] && !wr_hit[1] |=> st_reg.flags[1][5])
    else $error("external flag dropped without a write");

  chk_ext_falling: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.edge_falling && st_reg.ext_prev && !pins_sync[st_reg.pin_sel] |=> st_reg.flags[1][5])
    else $error("selected pin falling edge did not set external flag");

  chk_status_rise: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev.timer6_flag && !st_reg.flags[3][0] |=> st_reg.irq_status[24])
    else $error("new timer 6 flag did not reach the status register");

  chk_uart_error_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|src.uart_error_status_reg) |=> st_reg.flags[0][4])
    else $error("uart error summary missed its source");

  chk_twowire_sum_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|src.twowire_irq_status_reg) |=> st_reg.flags[0][0])
    else $error("two-wire summary missed its source");

  chk_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == |(st_reg.irq_status & st_reg.irq_enable))
    else $error("interrupt output disagrees with status and enable");
endmodule : pif_top

//--- common/pif_map.svh
// Purpose: Register offsets, field positions, masks and reset values of the flag block.
// Assumes: Byte addresses on a 32-bit AHB-Lite slave, one register per aligned word.
// Notes: Only the low eight address bits are decoded.
`ifndef PIF_MAP_SVH
`define PIF_MAP_SVH

`define PIF_ADDR_W 8
`define PIF_OFS_FLAGS_SIX 8'h00
`define PIF_OFS_FLAGS_SEVEN 8'h04
`define PIF_OFS_FLAGS_EIGHT 8'h08
`define PIF_OFS_FLAGS_NINE 8'h0c
`define PIF_OFS_PIN_SELECT 8'h10
`define PIF_OFS_IRQ_STATUS 8'h14
`define PIF_OFS_IRQ_CLEAR 8'h18
`define PIF_OFS_IRQ_ENABLE 8'h1c

`define PIF_WMASK_SIX 8'hc0
`define PIF_WMASK_SEVEN 8'h3b
`define PIF_WMASK_EIGHT 8'hc0
`define PIF_WMASK_NINE 8'h0f

`define PIF_PIN_COUNT 8
`define PIF_PINSEL_W 3
`define PIF_EDGE_BIT 8

`define PIF_FLAGS_RST 8'h00
`define PIF_PINSEL_RST 3'h0
`define PIF_WORD_RST 32'h0000_0000

`endif

//--- common/pif_pkg.sv
// Purpose: Types shared by the flag block and its bus slave.
// Assumes: Constants come from the map header.
// Notes: Event inputs are one-cycle pulses from logic on hclk.
`include "pif_map.svh"
package pif_pkg;
  typedef struct packed {
    logic timer3_gate_flag;
    logic timer3_overflow_flag;
    logic logic_cell2_flag;
    logic wave_gen2_flag;
    logic capcomp2_flag;
    logic timer4_flag;
    logic timer5_gate_flag;
    logic timer5_overflow_flag;
    logic logic_cell3_flag;
    logic wave_gen3_flag;
    logic capcomp3_flag;
    logic timer6_flag;
  } pif_events_s;

  typedef struct packed {
    logic [7:0] uart_irq_status_reg;
    logic [7:0] uart_error_status_reg;
    logic [7:0] twowire_error_reg;
    logic [7:0] twowire_irq_status_reg;
    logic uart2_transmit_flag;
    logic uart2_receive_flag;
  } pif_sources_s;

  typedef struct packed {
    logic wr_en;
    logic [`PIF_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } pif_reg_req_s;

  typedef struct packed {
    logic pend_wr;
    logic pend_rd;
    logic rd_done;
    logic [`PIF_ADDR_W-1:0] addr;
    logic [31:0] rdata;
  } pif_ahb_s;

  typedef struct packed {
    logic [3:0][7:0] flags;
    logic ext_prev;
    logic [`PIF_PINSEL_W-1:0] pin_sel;
    logic edge_falling;
    logic [31:0] irq_status;
    logic [31:0] irq_enable;
    logic irq;
  } pif_state_s;
endpackage : pif_pkg

//--- hw/pif_sync.sv
// Purpose: Two-flop synchroniser for a group of pins.
// Assumes: Each pin is a slow level; bits are not coherent with one another.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module pif_sync #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import pif_pkg::*;
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } pif_sync_s;
  pif_sync_s sync_reg;
  pif_sync_s sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = d;
    sync_next.stab = sync_reg.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.stab;
endmodule : pif_sync

//--- hw/pif_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the flag registers.
// Assumes: Single word transfers; response is always OKAY.
// Notes: Writes take no wait state; reads take one so that read data comes from a flop.
`timescale 1ns/10ps
module pif_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output pif_pkg::pif_reg_req_s req,
  input wire logic [31:0] rd_value
);
  import pif_pkg::*;
  pif_ahb_s bus_reg;
  pif_ahb_s bus_next;

  // The wait state lets a read that follows a write see the written value.
  always_comb begin
    bus_next = bus_reg;
    if (bus_reg.pend_rd && !bus_reg.rd_done) begin
      bus_next.rd_done = 1'b1;
      bus_next.rdata = rd_value;
    end
    if (hready) begin
      bus_next.pend_wr = 1'b0;
      bus_next.pend_rd = 1'b0;
      if (hsel && htrans[1]) begin
        bus_next.pend_wr = hwrite;
        bus_next.pend_rd = !hwrite;
        bus_next.rd_done = 1'b0;
        bus_next.addr = haddr[`PIF_ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg <= '0;
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign hreadyout = !(bus_reg.pend_rd && !bus_reg.rd_done);
  assign hresp = 1'b0;
  assign hrdata = bus_reg.rdata;
  assign req.wr_en = bus_reg.pend_wr;
  assign req.addr = bus_reg.addr;
  assign req.wdata = hwdata;
endmodule : pif_ahb_slave

//--- bench/pif_src_model.sv
// Purpose: Peripheral side of the flag block: event pulses, summary levels and pins.
// Assumes: Every output changes just after a rising hclk edge.
// Notes: Summary sources are levels that the bench sets; events are single pulses.
`timescale 1ns/10ps
`include "pif_map.svh"
module pif_src_model (
  input wire logic hclk,
  output pif_pkg::pif_events_s ev,
  output pif_pkg::pif_sources_s src,
  output logic [`PIF_PIN_COUNT-1:0] ext_pins
);
  import pif_pkg::*;
  initial begin
    ev = '0;
    src = '0;
    ext_pins = '0;
  end
  // A held event would count as a stream of events, so it drops after one edge.
  task pulse(input pif_events_s m);
    ev <= m;
    @(posedge hclk);
    ev <= '0;
  endtask : pulse
  task drive(input pif_sources_s s, input logic [`PIF_PIN_COUNT-1:0] p);
    src <= s;
    ext_pins <= p;
  endtask : drive
endmodule : pif_src_model

//--- bench/pif_top_bench.sv
// Purpose: Self-checking bench of the flag block over AHB-Lite.
// Assumes: The master waits on hready; reads are compared by a monitor from a queue.
// Notes: Flags and irq are looked at mid-cycle, where they are settled.
`timescale 1ns/10ps
`include "pif_map.svh"
module pif_top_bench;
  import pif_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, rd_ph;
  logic [31:0] hrdata, flags_out;
  pif_events_s ev;
  pif_sources_s src;
  logic [`PIF_PIN_COUNT-1:0] ext_pins;
  logic [31:0] exp_q[$];
  logic [31:0] rng = 32'h11;
  int n_errors = 0;
  int n_checks = 0;
  always #5 hclk = ~hclk;
  pif_src_model i_pif_src_model (.hclk(hclk), .ev(ev), .src(src), .ext_pins(ext_pins));
  pif_top i_pif_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ev(ev), .src(src),
    .ext_pins(ext_pins), .flags_out(flags_out), .irq(irq));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  function automatic logic [31:0] ev_map(input pif_events_s e);
    return {4'h0, e.logic_cell3_flag, e.wave_gen3_flag, e.capcomp3_flag, e.timer6_flag,
      e.timer5_gate_flag, e.timer5_overflow_flag, 6'h00, 3'h0, e.logic_cell2_flag,
      e.wave_gen2_flag, 1'b0, e.capcomp2_flag, e.timer4_flag, e.timer3_gate_flag,
      e.timer3_overflow_flag, 6'h00};
  endfunction : ev_map
  task check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  // The level that counts is the one sampled at the edge, so it is read just before.
  task wait_rdy;
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask : wait_rdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    if (!w) exp_q.push_back(d);
    wait_rdy();
    htrans <= 2'h0;
    if (w) hwdata <= d;
    wait_rdy();
  endtask : xfer
  task cout(input logic [31:0] f, input logic i);
    @(negedge hclk);
    check(flags_out, f);
    check({31'h0, irq}, {31'h0, i});
    @(posedge hclk);
  endtask : cout
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
    end else begin
      if (rd_ph && hreadyout) begin
        rd_ph <= 1'b0;
        check(hrdata, exp_q.pop_front());
        check({31'h0, hresp}, 32'h0);
      end
      if (hreadyout && htrans[1] && !hwrite) rd_ph <= 1'b1;
    end
  end
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    close_out();
  end
  initial begin
    pif_events_s e;
    pif_sources_s s;
    logic [31:0] x;
    x = 32'h0;
    tick(4);
    hresetn <= 1'b1;
    tick(1);
    for (int a = 0; a < 36; a += 4) xfer(1'b0, a[7:0], 32'h0);
    $display("test reset_values done");
    for (int k = 0; k < 6; k++) begin
      e = 12'(xs());
      i_pif_src_model.pulse(e);
      x = x | ev_map(e);
      cout(x, 1'b0);
    end
    i_pif_src_model.pulse('1);
    x = ev_map('1);
    for (int j = 0; j < 4; j++) xfer(1'b0, 8'(4 * j), (x >> (8 * j)) & 32'hff);
    for (int j = 0; j < 4; j++) xfer(1'b1, 8'(4 * j), 32'h0);
    cout(32'h0, 1'b0);
    for (int j = 0; j < 4; j++) xfer(1'b1, 8'(4 * j), 32'hff);
    cout({`PIF_WMASK_NINE, `PIF_WMASK_EIGHT, `PIF_WMASK_SEVEN, `PIF_WMASK_SIX}, 1'b0);
    for (int j = 0; j < 4; j++) xfer(1'b1, 8'(4 * j), 32'h0);
    $display("test event_flags done");
    for (int b = 0; b < 6; b++) begin
      s = '0;
      case (b)
        0: s.twowire_irq_status_reg = 8'h81;
        1: s.twowire_error_reg = 8'h81;
        2: s.uart2_receive_flag = 1'b1;
        3: s.uart2_transmit_flag = 1'b1;
        4: s.uart_error_status_reg = 8'h81;
        default: s.uart_irq_status_reg = 8'h81;
      endcase
      xfer(1'b1, 8'h00, 32'h3f);
      cout(32'h0, 1'b0);
      i_pif_src_model.drive(s, '0);
      tick(3);
      xfer(1'b1, 8'h00, 32'h0);
      cout(32'h1 << b, 1'b0);
      i_pif_src_model.drive(s & {{4{8'h7f}}, 2'b11}, '0);
      tick(3);
      cout(32'h1 << b, 1'b0);
      i_pif_src_model.drive('0, '0);
      tick(3);
      cout(32'h0, 1'b0);
    end
    $display("test summaries done");
    xfer(1'b1, 8'h10, 32'h5);
    xfer(1'b0, 8'h10, 32'h5);
    tick(4);
    xfer(1'b1, 8'h04, 32'h0);
    i_pif_src_model.drive('0, 8'h04);
    tick(5);
    cout(32'h0, 1'b0);
    i_pif_src_model.drive('0, 8'h24);
    tick(5);
    cout(32'h2000, 1'b0);
    xfer(1'b1, 8'h10, 32'h105);
    tick(4);
    xfer(1'b1, 8'h04, 32'h0);
    i_pif_src_model.drive('0, 8'h04);
    tick(5);
    cout(32'h2000, 1'b0);
    xfer(1'b1, 8'h04, 32'h0);
    $display("test pin_select done");
    xfer(1'b1, 8'h18, 32'hffff_ffff);
    xfer(1'b0, 8'h14, 32'h0);
    e = '0;
    e.timer6_flag = 1'b1;
    i_pif_src_model.pulse(e);
    cout(32'h0100_0000, 1'b0);
    xfer(1'b0, 8'h14, 32'h0100_0000);
    xfer(1'b1, 8'h1c, 32'h0100_0000);
    tick(2);
    cout(32'h0100_0000, 1'b1);
    xfer(1'b1, 8'h1c, 32'h0);
    tick(2);
    cout(32'h0100_0000, 1'b0);
    xfer(1'b1, 8'h18, 32'h0100_0000);
    xfer(1'b0, 8'h18, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    xfer(1'b1, 8'h0c, 32'h0);
    xfer(1'b1, 8'h1c, 32'h0100_0000);
    tick(2);
    cout(32'h0, 1'b0);
    $display("test interrupt done");
    i_pif_src_model.pulse('1);
    hresetn <= 1'b0;
    tick(2);
    cout(32'h0, 1'b0);
    hresetn <= 1'b1;
    tick(1);
    xfer(1'b0, 8'h10, 32'h0);
    xfer(1'b0, 8'h1c, 32'h0);
    tick(4);
    check(32'(exp_q.size()), 32'h0);
    $display("test second_reset done");
    close_out();
  end
endmodule : pif_top_bench
